/* src/dog_based_homing_sequencer.sv */
// home-return sequencer: count-type front end, dog cradle and last index methods
// assumes enc_position and creep_reached come from logic on ref_clk; dog and
// index pins are asynchronous and are synchronised here
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module dog_based_homing_sequencer
  import homing_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // classic wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  // mode select inputs
  input  wire logic        homing_mode_select,
  input  wire logic        table_select_bit0,
  input  wire logic        table_select_bit1,
  input  wire logic        table_select_bit2,
  input  wire logic        table_select_bit3,
  input  wire logic        table_select_bit4,
  // sensors and feedback
  input  wire logic        proximity_dog_pin,
  input  wire logic        index_pulse_pin,
  input  wire logic [31:0] enc_position,
  input  wire logic        creep_reached,
  // motion command side
  output logic [31:0]      speed_cmd,
  output logic             dir_reverse,
  output logic [3:0]       accel_table_sel,
  output logic             position_load,
  output logic [31:0]      position_load_value,
  output logic             homing_done_output,
  output logic             homing_incomplete_alarm
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // distance moved from ref_pos in the homing travel sense
  function automatic logic [31:0] travelled(input logic [31:0] pos,
                                            input logic [31:0] ref_pos,
                                            input logic        rev);
    return rev ? (ref_pos - pos) : (pos - ref_pos);
  endfunction

  // ************************************************************
  // input synchronisers and edge detection
  // ************************************************************
  logic [1:0] dog_sync_r, dog_sync_nxt;
  logic [1:0] idx_sync_r, idx_sync_nxt;
  logic       dog_last_r, dog_last_nxt, idx_last_r, idx_last_nxt, req_last_r, req_last_nxt;
  logic       dog_level, dog_front, idx_rise, homing_req, req_rise;
  logic [4:0] method_r, method_nxt;
  logic [31:0] hspeed_r, hspeed_nxt, cspeed_r, cspeed_nxt;
  logic [31:0] shift_r, shift_nxt, preset_r, preset_nxt, postdist_r, postdist_nxt;
  logic        pol_r, pol_nxt;

  assign dog_level  = dog_sync_r[1] ^ pol_r;
  assign dog_front  = dog_level & ~dog_last_r;
  assign idx_rise   = idx_sync_r[1] & ~idx_last_r;
  assign homing_req = homing_mode_select & ~(table_select_bit0 | table_select_bit1 |
                      table_select_bit2 | table_select_bit3 | table_select_bit4);
  assign req_rise   = homing_req & ~req_last_r;
  always_comb begin
    dog_sync_nxt = {dog_sync_r[0], proximity_dog_pin};
    idx_sync_nxt = {idx_sync_r[0], index_pulse_pin};
    dog_last_nxt = dog_level;
    idx_last_nxt = idx_sync_r[1];
    req_last_nxt = homing_req;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dog_sync_r <= 2'h0;
      idx_sync_r <= 2'h0;
      dog_last_r <= 1'b0;
      idx_last_r <= 1'b0;
      req_last_r <= 1'b0;
    end else begin
      dog_sync_r <= dog_sync_nxt;
      idx_sync_r <= idx_sync_nxt;
      dog_last_r <= dog_last_nxt;
      idx_last_r <= idx_last_nxt;
      req_last_r <= req_last_nxt;
    end
  end

  // ************************************************************
  // homing sequencer
  // ************************************************************
  home_state_t state_r, state_nxt;
  logic [31:0] ref_pos_r, ref_pos_nxt, capture_r, capture_nxt;
  logic [31:0] speed_r, speed_nxt, load_val_r, load_val_nxt;
  logic        dir_r, dir_nxt, creep_seen_r, creep_seen_nxt;
  logic        done_r, done_nxt, alarm_r, alarm_nxt, load_r, load_nxt;
  logic [3:0]  method_code;
  logic        method_rev;
  logic [31:0] moved, count_dist;

  assign method_code = method_r[METHOD_CODE_MSB:0];
  assign method_rev  = method_r[METHOD_DIR_BIT];
  assign moved       = travelled(enc_position, ref_pos_r, dir_r);
  assign count_dist  = postdist_r + shift_r;
  always_comb begin
    state_nxt      = state_r;
    ref_pos_nxt    = ref_pos_r;
    capture_nxt    = capture_r;
    speed_nxt      = speed_r;
    dir_nxt        = dir_r;
    creep_seen_nxt = creep_seen_r;
    done_nxt       = done_r;
    alarm_nxt      = alarm_r;
    load_nxt       = 1'b0;
    load_val_nxt   = load_val_r;
    if (state_r inside {ST_TRAVEL, ST_SEEK_INDEX, ST_REVERSE, ST_SHIFT} && creep_reached) begin
      creep_seen_nxt = 1'b1;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (req_rise && (method_code == METHOD_COUNT_FRONT ||
                         method_code == METHOD_DOG_CRADLE ||
                         method_code == METHOD_LAST_INDEX)) begin
          state_nxt      = ST_FAST;
          speed_nxt      = hspeed_r;
          dir_nxt        = method_rev;
          creep_seen_nxt = 1'b0;
          done_nxt       = 1'b0;
          alarm_nxt      = 1'b0;
        end
      end
      ST_FAST: begin
        if (dog_front) begin
          ref_pos_nxt = enc_position;
          speed_nxt   = cspeed_r;
          if (method_code == METHOD_COUNT_FRONT) begin
            state_nxt = ST_TRAVEL;
          end else if (method_code == METHOD_DOG_CRADLE) begin
            state_nxt = ST_SEEK_INDEX;
          end else begin
            state_nxt = ST_REVERSE;
            dir_nxt   = ~dir_r;
          end
        end
      end
      ST_TRAVEL: begin
        if (moved >= count_dist) begin
          if (creep_seen_r || creep_reached) begin
            state_nxt    = ST_DONE;
            load_nxt     = 1'b1;
            load_val_nxt = preset_r;
            done_nxt     = 1'b1;
          end else begin
            state_nxt = ST_FAULT;
            alarm_nxt = 1'b1;
          end
          speed_nxt = 32'h0000_0000;
        end
      end
      ST_SEEK_INDEX, ST_REVERSE: begin
        if (idx_rise) begin
          capture_nxt = enc_position;
          ref_pos_nxt = enc_position;
          state_nxt   = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (moved >= shift_r) begin
          state_nxt    = ST_DONE;
          speed_nxt    = 32'h0000_0000;
          load_nxt     = 1'b1;
          load_val_nxt = preset_r;
          done_nxt     = 1'b1;
        end
      end
      ST_DONE, ST_FAULT: begin
        if (!homing_req) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // dropping the request mid-run forces idle and zero speed; done, load and alarm set in the same cycle are not gated
    if (!homing_req && state_r inside {ST_FAST, ST_TRAVEL, ST_SEEK_INDEX,
                                       ST_REVERSE, ST_SHIFT}) begin
      state_nxt = ST_IDLE;
      speed_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      ref_pos_r    <= 32'h0000_0000;
      capture_r    <= 32'h0000_0000;
      speed_r      <= 32'h0000_0000;
      dir_r        <= 1'b0;
      creep_seen_r <= 1'b0;
      done_r       <= 1'b0;
      alarm_r      <= 1'b0;
      load_r       <= 1'b0;
      load_val_r   <= 32'h0000_0000;
    end else begin
      state_r      <= state_nxt;
      ref_pos_r    <= ref_pos_nxt;
      capture_r    <= capture_nxt;
      speed_r      <= speed_nxt;
      dir_r        <= dir_nxt;
      creep_seen_r <= creep_seen_nxt;
      done_r       <= done_nxt;
      alarm_r      <= alarm_nxt;
      load_r       <= load_nxt;
      load_val_r   <= load_val_nxt;
    end
  end

  assign speed_cmd               = speed_r;
  assign dir_reverse             = dir_r;
  assign accel_table_sel         = ACCEL_TABLE_ENTRY;
  assign position_load           = load_r;
  assign position_load_value     = load_val_r;
  assign homing_done_output      = done_r;
  assign homing_incomplete_alarm = alarm_r;

  // ************************************************************
  // wishbone register file
  // ************************************************************
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_en;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  always_comb begin
    method_nxt   = method_r;
    hspeed_nxt   = hspeed_r;
    cspeed_nxt   = cspeed_r;
    shift_nxt    = shift_r;
    preset_nxt   = preset_r;
    postdist_nxt = postdist_r;
    pol_nxt      = pol_r;
    ack_nxt      = wb_cyc_i & wb_stb_i & ~ack_r;
    rdata_nxt    = 32'h0000_0000;
    if (wr_en) begin
      unique case (wb_adr_i)
        OFS_METHOD:   method_nxt   = 5'(merge_bytes({27'h0, method_r}, wb_dat_i, wb_sel_i));
        OFS_HSPEED:   hspeed_nxt   = merge_bytes(hspeed_r, wb_dat_i, wb_sel_i);
        OFS_CSPEED:   cspeed_nxt   = merge_bytes(cspeed_r, wb_dat_i, wb_sel_i);
        OFS_SHIFT:    shift_nxt    = merge_bytes(shift_r, wb_dat_i, wb_sel_i);
        OFS_PRESET:   preset_nxt   = merge_bytes(preset_r, wb_dat_i, wb_sel_i);
        OFS_POSTDIST: postdist_nxt = merge_bytes(postdist_r, wb_dat_i, wb_sel_i);
        OFS_POLARITY: pol_nxt      = wb_sel_i[0] ? wb_dat_i[POL_DOG_BIT] : pol_r;
        default: ;
      endcase
    end
    unique case (wb_adr_i)
      OFS_METHOD:   rdata_nxt = {27'h0, method_r};
      OFS_HSPEED:   rdata_nxt = hspeed_r;
      OFS_CSPEED:   rdata_nxt = cspeed_r;
      OFS_SHIFT:    rdata_nxt = shift_r;
      OFS_PRESET:   rdata_nxt = preset_r;
      OFS_POSTDIST: rdata_nxt = postdist_r;
      OFS_POLARITY: rdata_nxt = {31'h0, pol_r};
      OFS_STATUS: begin
        rdata_nxt[ST_BUSY_BIT]                 = !(state_r inside {ST_IDLE, ST_DONE, ST_FAULT});
        rdata_nxt[ST_DONE_BIT]                 = done_r;
        rdata_nxt[ST_ALARM_BIT]                = alarm_r;
        rdata_nxt[ST_CREEP_BIT]                = creep_seen_r;
        rdata_nxt[ST_STATE_LSB +: 3]           = state_r;
      end
      OFS_CAPTURE:  rdata_nxt = capture_r;
      default:      rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      method_r   <= METHOD_RST;
      hspeed_r   <= HSPEED_RST;
      cspeed_r   <= CSPEED_RST;
      shift_r    <= DIST_RST;
      preset_r   <= DIST_RST;
      postdist_r <= DIST_RST;
      pol_r      <= 1'b0;
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      method_r   <= method_nxt;
      hspeed_r   <= hspeed_nxt;
      cspeed_r   <= cspeed_nxt;
      shift_r    <= shift_nxt;
      preset_r   <= preset_nxt;
      postdist_r <= postdist_nxt;
      pol_r      <= pol_nxt;
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

endmodule

/* src/homing_pkg.sv */
// constants for the dog based homing sequencer: register map, field layout,
// method codes and reset values; no assumptions beyond a 32-bit register bus
package homing_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_METHOD   = 8'h00;
  localparam logic [7:0] OFS_HSPEED   = 8'h04;
  localparam logic [7:0] OFS_CSPEED   = 8'h08;
  localparam logic [7:0] OFS_SHIFT    = 8'h0c;
  localparam logic [7:0] OFS_PRESET   = 8'h10;
  localparam logic [7:0] OFS_POSTDIST = 8'h14;
  localparam logic [7:0] OFS_POLARITY = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_CAPTURE  = 8'h20;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int METHOD_CODE_MSB = 3;
  localparam int METHOD_DIR_BIT  = 4;
  localparam int POL_DOG_BIT     = 0;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_DONE_BIT     = 1;
  localparam int ST_ALARM_BIT    = 2;
  localparam int ST_CREEP_BIT    = 3;
  localparam int ST_STATE_LSB    = 8;

  // ************************************************************
  // method codes and reset values
  // ************************************************************
  localparam logic [3:0]  METHOD_COUNT_FRONT = 4'h6;
  localparam logic [3:0]  METHOD_DOG_CRADLE  = 4'h7;
  localparam logic [3:0]  METHOD_LAST_INDEX  = 4'h8;
  localparam logic [4:0]  METHOD_RST         = 5'h06;
  localparam logic [31:0] HSPEED_RST         = 32'h0000_0000;
  localparam logic [31:0] CSPEED_RST         = 32'h0000_0000;
  localparam logic [31:0] DIST_RST           = 32'h0000_0000;
  localparam logic [3:0]  ACCEL_TABLE_ENTRY  = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FAST, ST_TRAVEL, ST_SEEK_INDEX, ST_REVERSE, ST_SHIFT, ST_DONE, ST_FAULT
  } home_state_t;

endpackage

/* testbench/axis_model.sv */
// axis model: integrates the speed command into a position, with two sensor
// windows and an index mark every 256 counts; assumes one clock with the design
`timescale 1ns/1ps
module axis_model #(
  parameter logic [31:0] CREEP = 32'h0000_0004
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] speed_cmd,
  input  wire logic        dir_reverse,
  input  wire logic        dog_active_low,
  input  wire logic        creep_en,
  output logic      [31:0] enc_position,
  output logic             proximity_dog_pin,
  output logic             index_pulse_pin,
  output logic             creep_reached
);
  // ************************************************************
  // position and sensors
  // ************************************************************
  logic [31:0] pos_r, pos_nxt;

  always_comb begin
    pos_nxt = dir_reverse ? pos_r - speed_cmd : pos_r + speed_cmd;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pos_r <= 32'h0000_1000;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  assign enc_position = pos_r;
  // sensor windows at 0x0800 and 0x1400, each 0x400 counts long
  assign proximity_dog_pin = ((pos_r[15:10] == 6'h05) || (pos_r[15:10] == 6'h02)) ^ dog_active_low;
  assign index_pulse_pin = (pos_r[7:5] == 3'h6);
  // creep_en low models a profiler that never settles at creep speed
  assign creep_reached = creep_en && (speed_cmd == CREEP) && (speed_cmd != 32'h0);
endmodule

/* testbench/homing_chk.sv */
// checker for the homing sequencer, bound to the ports of its top module
// assumes the bus master writes whole words (all byte lanes enabled)
`timescale 1ns/1ps
module homing_chk
  import homing_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_we_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o,
  input wire logic        homing_mode_select,
  input wire logic        table_select_bit0,
  input wire logic        table_select_bit1,
  input wire logic        table_select_bit2,
  input wire logic        table_select_bit3,
  input wire logic        table_select_bit4,
  input wire logic        proximity_dog_pin,
  input wire logic [31:0] speed_cmd,
  input wire logic        dir_reverse,
  input wire logic [3:0]  accel_table_sel,
  input wire logic        position_load,
  input wire logic [31:0] position_load_value,
  input wire logic        homing_done_output,
  input wire logic        homing_incomplete_alarm
);
  // ************************************************************
  // shadow copies of the setting registers
  // ************************************************************
  logic [4:0]  meth_r, meth_nxt;
  logic [31:0] hspd_r, hspd_nxt, cspd_r, cspd_nxt, pre_r, pre_nxt;
  logic        pol_r, pol_nxt, req, dog_act, code_ok;

  assign req = homing_mode_select & ~(table_select_bit0 | table_select_bit1 |
    table_select_bit2 | table_select_bit3 | table_select_bit4);
  assign dog_act = proximity_dog_pin ^ pol_r;
  assign code_ok = meth_r[3:0] inside {METHOD_COUNT_FRONT, METHOD_DOG_CRADLE, METHOD_LAST_INDEX};

  always_comb begin
    {meth_nxt, hspd_nxt, cspd_nxt, pre_nxt, pol_nxt} = {meth_r, hspd_r, cspd_r, pre_r, pol_r};
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      case (wb_adr_i)
        OFS_METHOD:   meth_nxt = wb_dat_i[4:0];
        OFS_HSPEED:   hspd_nxt = wb_dat_i;
        OFS_CSPEED:   cspd_nxt = wb_dat_i;
        OFS_PRESET:   pre_nxt = wb_dat_i;
        OFS_POLARITY: pol_nxt = wb_dat_i[POL_DOG_BIT];
        default:      ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {meth_r, hspd_r, cspd_r, pre_r, pol_r} <= {METHOD_RST, 97'h0};
    end else begin
      {meth_r, hspd_r, cspd_r, pre_r, pol_r} <= {meth_nxt, hspd_nxt, cspd_nxt, pre_nxt, pol_nxt};
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_ACCEL_ENTRY: assert property (accel_table_sel == ACCEL_TABLE_ENTRY)
    else $error("accel table select is not entry one");
  AST_DROP_STOP: assert property (!req |=> speed_cmd == 32'h0)
    else $error("axis moves without a homing request");
  AST_START_FAST: assert property ($rose(req) && code_ok |=>
    speed_cmd == hspd_r && dir_reverse == meth_r[METHOD_DIR_BIT])
    else $error("start speed or direction wrong");
  AST_BAD_CODE: assert property ($rose(req) && !code_ok |=> (speed_cmd == 32'h0) [*4])
    else $error("unknown method started motion");
  AST_DOG_CREEP: assert property (speed_cmd == hspd_r && hspd_r != cspd_r &&
    $rose(dog_act) |-> ##[2:6] speed_cmd == cspd_r)
    else $error("no creep speed after sensor front end");
  AST_CREEP_HOLD: assert property ($past(speed_cmd) == cspd_r && speed_cmd != 32'h0 |->
    speed_cmd == cspd_r)
    else $error("left creep speed while moving");
  AST_TURN: assert property ($past(speed_cmd) == hspd_r && speed_cmd == cspd_r &&
    hspd_r != cspd_r |-> ##[0:1]
    dir_reverse == (meth_r[METHOD_DIR_BIT] ^ (meth_r[3:0] == METHOD_LAST_INDEX)))
    else $error("direction at sensor front end wrong");
  AST_LOAD_PRESET: assert property (position_load |-> position_load_value == pre_r)
    else $error("load value differs from preset");
  AST_LOAD_DONE: assert property (position_load |-> homing_done_output &&
    speed_cmd == 32'h0)
    else $error("load without completion");
  AST_LOAD_ONCE: assert property (position_load |=> !position_load)
    else $error("load pulse longer than one cycle");
  AST_ALARM_STOP: assert property ($rose(homing_incomplete_alarm) |->
    !homing_done_output && !position_load && speed_cmd == 32'h0)
    else $error("alarm raised with completion or motion");

  cover property (position_load && dir_reverse);
  cover property ($rose(homing_incomplete_alarm));
  cover property ($past(speed_cmd) == hspd_r && speed_cmd == cspd_r && dir_reverse);
endmodule

bind dog_based_homing_sequencer homing_chk chk (.*);

/* testbench/testbench.sv */
// self-checking bench for the homing sequencer
// assumes axis_model as the far side and homing_chk bound to the design
`timescale 1ns/1ps
module testbench
  import homing_pkg::*;
;
  // ************************************************************
  // signals and instances
  // ************************************************************
  localparam logic [31:0] HS = 32'h0000_0018;
  localparam logic [31:0] CS = 32'h0000_0004;
  localparam logic [31:0] SHIFT = 32'h0000_0080;
  localparam logic [31:0] POST = 32'h0000_0100;
  localparam logic [31:0] PRE = 32'h0000_5a5a;
  logic        ref_clk, rst, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, homing_mode_select;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, accel_table_sel;
  logic [4:0]  tsel;
  logic [31:0] wb_dat_i, wb_dat_o, enc_position, speed_cmd, position_load_value, rd;
  logic        proximity_dog_pin, index_pulse_pin, creep_reached, dir_reverse, position_load;
  logic        homing_done_output, homing_incomplete_alarm, dog_active_low, creep_en;
  wire logic   table_select_bit0, table_select_bit1, table_select_bit2, table_select_bit3;
  wire logic   table_select_bit4;
  int          mismatches = 0;
  int          n_checks = 0;

  assign {table_select_bit4, table_select_bit3, table_select_bit2, table_select_bit1,
    table_select_bit0} = tsel;
  dog_based_homing_sequencer uut (.*);
  axis_model #(.CREEP(CS)) partner (.*);

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] inr(input logic [31:0] v, input logic [31:0] lo, hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask

  task automatic prog(input logic [31:0] m, input logic pol, input logic creep);
    rst <= 1'h1;
    homing_mode_select <= 1'h0;
    dog_active_low <= pol;
    creep_en <= creep;
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    wb(1'h1, OFS_METHOD, m);
    wb(1'h1, OFS_HSPEED, HS);
    wb(1'h1, OFS_CSPEED, CS);
    wb(1'h1, OFS_SHIFT, SHIFT);
    wb(1'h1, OFS_POSTDIST, POST);
    wb(1'h1, OFS_PRESET, PRE);
    wb(1'h1, OFS_POLARITY, {31'h0, pol});
  endtask

  task automatic home(input logic alarm, output logic [31:0] p);
    homing_mode_select <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (position_load !== 1'h1 && homing_incomplete_alarm !== 1'h1);
    p = enc_position;
    if (!alarm) check(position_load_value, PRE);
    @(posedge ref_clk);
    check({homing_done_output, homing_incomplete_alarm}, {!alarm, alarm});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    prog(32'h6, 1'h0, 1'h1);
    wb(1'h0, OFS_HSPEED, 32'h0);
    check(rd, HS);
    wb(1'h1, 8'h44, 32'hffff_ffff);
    wb(1'h0, 8'h44, 32'h0);
    check(rd, 32'h0);
    wb(1'h1, OFS_STATUS, 32'hffff_ffff);
    wb(1'h0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    wb(1'h0, OFS_PRESET, 32'h0);
    check(rd, PRE);
  endtask

  task automatic t_refuse();
    prog(32'h6, 1'h0, 1'h1);
    for (int i = 0; i < 5; i++) begin
      tsel <= 5'h01 << i;
      homing_mode_select <= 1'h1;
      repeat (8) @(posedge ref_clk);
      check(speed_cmd, 32'h0);
      homing_mode_select <= 1'h0;
      tsel <= 5'h00;
      @(posedge ref_clk);
    end
    wb(1'h1, OFS_METHOD, 32'h5);
    homing_mode_select <= 1'h1;
    repeat (8) @(posedge ref_clk);
    check(speed_cmd, 32'h0);
    // valid start, then the request drops mid-run: the axis must stop
    homing_mode_select <= 1'h0;
    wb(1'h1, OFS_METHOD, 32'h6);
    homing_mode_select <= 1'h1;
    repeat (3) @(posedge ref_clk);
    check(speed_cmd, HS);
    homing_mode_select <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check(speed_cmd, 32'h0);
  endtask

  task automatic t_count();
    logic [31:0] p;
    prog(32'h6, 1'h0, 1'h1);
    home(1'h0, p);
    check(inr(p, 32'h1580, 32'h1680), 32'h1);
    prog(32'h16, 1'h1, 1'h1);
    home(1'h0, p);
    check(inr(p, 32'h0980, 32'h0a80), 32'h1);
    prog(32'h6, 1'h0, 1'h0);
    home(1'h1, p);
  endtask

  task automatic t_index(input logic [31:0] m, input logic [31:0] lo);
    logic [31:0] p;
    prog(m, 1'h0, 1'h1);
    home(1'h0, p);
    wb(1'h0, OFS_CAPTURE, 32'h0);
    check(inr(rd, lo, lo + 32'h20), 32'h1);
    if (m == 32'h7) check(inr(p - rd, SHIFT, SHIFT + 32'h20), 32'h1);
    else check(inr(rd - p, SHIFT, SHIFT + 32'h20), 32'h1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  initial begin
    rst = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
    wb_sel_i = 4'hf;
    {homing_mode_select, tsel, dog_active_low, creep_en} = 8'h1;
    @(posedge ref_clk);
    t_regs();
    t_refuse();
    t_count();
    t_index(32'h7, 32'h14c0);
    t_index(32'h8, 32'h13c0);
    summarize();
  end
endmodule
